// [tap_map.svh]
// Constant map of the boundary-scan test port
`ifndef TAP_MAP_SVH
`define TAP_MAP_SVH

// Instruction register
`define TAP_IR_WIDTH 5
`define TAP_IR_MSB 4
`define TAP_IR_CAPTURE 5'h01
`define TAP_IR_EXTEST 5'h00
`define TAP_IR_SAMPLE 5'h01
`define TAP_IR_IDCODE 5'h02
`define TAP_IR_HIGHZ 5'h03
`define TAP_IR_BYPASS 5'h1f

// Boundary register layout
`define TAP_BSR_LEN 297
`define TAP_BSR_MSB 296
`define TAP_RSVD_BIT 0
`define TAP_OUT_CELLS 145
`define TAP_OUT_BASE 1
`define TAP_IN_CELLS 6
`define TAP_IN_BASE 291

// Identification register
`define TAP_ID_WIDTH 32
`define TAP_ID_MSB 31

// Sampled pad vector width
`define TAP_SAMPLE_WIDTH 441
// Drive vector width
`define TAP_DRIVE_WIDTH 292

`endif

// [tap_pkg.sv]
// Types of the boundary-scan test port
`include "tap_map.svh"

package tap_pkg;

  // Controller states, Gray coded along the usual path
  typedef enum logic [3:0] {
    tap_reset = 4'h0,
    tap_idle = 4'h1,
    tap_sel_dr = 4'h3,
    tap_cap_dr = 4'h2,
    tap_shift_dr = 4'h6,
    tap_ex1_dr = 4'h7,
    tap_pause_dr = 4'h5,
    tap_ex2_dr = 4'h4,
    tap_upd_dr = 4'hc,
    tap_sel_ir = 4'hd,
    tap_cap_ir = 4'hf,
    tap_shift_ir = 4'he,
    tap_ex1_ir = 4'ha,
    tap_pause_ir = 4'hb,
    tap_ex2_ir = 4'h9,
    tap_upd_ir = 4'h8
  } tap_state_type;

  // Data register chosen by the instruction
  typedef enum logic [1:0] {
    sel_bsr = 2'h0,
    sel_id = 2'h1,
    sel_bypass = 2'h2
  } dr_select_type;

  // Test clock domain state
  typedef struct packed {
    tap_state_type state;
    logic [`TAP_IR_MSB:0] ir_shift;
    logic [`TAP_IR_MSB:0] ir_out;
    logic [`TAP_BSR_MSB:0] bsr_shift;
    logic [`TAP_BSR_MSB:0] bsr_out;
    logic [`TAP_ID_MSB:0] id_shift;
    logic bypass;
    logic extest;
    logic highz;
  } tck_state_type;

  // Pad levels seen by the test clock domain
  typedef struct packed {
    logic [`TAP_OUT_CELLS-1:0] pad_in;
    logic [`TAP_OUT_CELLS-1:0] drive_data;
    logic [`TAP_OUT_CELLS-1:0] drive_enable;
    logic [`TAP_IN_CELLS-1:0] in_pin;
  } pad_sample_type;

  // Test drive handed to the system clock domain
  typedef struct packed {
    logic extest;
    logic highz;
    logic [`TAP_OUT_CELLS-1:0] data;
    logic [`TAP_OUT_CELLS-1:0] enable;
  } scan_drive_type;

  // System clock domain state
  typedef struct packed {
    logic [`TAP_OUT_CELLS-1:0] pad_data;
    logic [`TAP_OUT_CELLS-1:0] pad_enable;
  } sys_state_type;

  localparam tck_state_type tck_reset_value = '{
    state: tap_reset,
    ir_shift: `TAP_IR_CAPTURE,
    ir_out: `TAP_IR_IDCODE,
    bsr_shift: '0,
    bsr_out: '0,
    id_shift: '0,
    bypass: 1'b0,
    extest: 1'b0,
    highz: 1'b0
  };

endpackage

// [level_sync.sv]
// Two-flop level synchroniser
`timescale 1ns/10ps

module level_sync #(
  parameter int WIDTH = 1
) (
  // Clock and clear
  input wire logic clock,
  input wire logic clear,
  // Levels
  input wire logic [WIDTH-1:0] level_in,
  output logic [WIDTH-1:0] level_out
);

  logic [1:0][WIDTH-1:0] stage_reg;
  logic [1:0][WIDTH-1:0] stage_next;

  // First stage feeds only the second
  always_comb
  begin
    stage_next[0] = level_in;
    stage_next[1] = stage_reg[0];
    if (clear)
    begin
      stage_next = '0;
    end
  end

  always_ff @(posedge clock)
  begin
    stage_reg <= stage_next;
  end

  assign level_out = stage_reg[1];

endmodule // level_sync

// [boundary_scan_tap.sv]
// Boundary-scan test access port with pad multiplexing
`timescale 1ns/10ps
`include "tap_map.svh"

module boundary_scan_tap #(
  // Identification fields, values arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h1234,
  parameter logic [10:0] ID_MAKER = 11'h2aa
) (
  // System clock and reset
  input wire logic clock,
  input wire logic reset,
  // Test port
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  // Core side of the pads
  input wire logic [`TAP_OUT_CELLS-1:0] core_out_data,
  input wire logic [`TAP_OUT_CELLS-1:0] core_out_enable,
  // Bidirectional pads
  input wire logic [`TAP_OUT_CELLS-1:0] pad_in,
  output logic [`TAP_OUT_CELLS-1:0] pad_out_data,
  output logic [`TAP_OUT_CELLS-1:0] pad_out_enable,
  // Input-only pads
  input wire logic [`TAP_IN_CELLS-1:0] in_pin
);

  tap_pkg::tck_state_type t_reg;
  tap_pkg::tck_state_type t_next;
  tap_pkg::sys_state_type s_reg;
  tap_pkg::sys_state_type s_next;
  logic tdo_reg;
  logic tdo_next;
  tap_pkg::pad_sample_type pad_now;
  tap_pkg::pad_sample_type pad_seen;
  tap_pkg::scan_drive_type drive_tck;
  tap_pkg::scan_drive_type drive_sys;
  tap_pkg::dr_select_type dr_sel;

  // Instruction decode
  function automatic tap_pkg::dr_select_type dr_select(input logic [`TAP_IR_MSB:0] ir);
    case (ir)
      `TAP_IR_EXTEST: dr_select = tap_pkg::sel_bsr;
      `TAP_IR_SAMPLE: dr_select = tap_pkg::sel_bsr;
      `TAP_IR_IDCODE: dr_select = tap_pkg::sel_id;
      default: dr_select = tap_pkg::sel_bypass;
    endcase
  endfunction

  // Controller next state
  function automatic tap_pkg::tap_state_type tap_next(input tap_pkg::tap_state_type st,
                                                      input logic mode);
    case (st)
      tap_pkg::tap_reset: tap_next = mode ? tap_pkg::tap_reset : tap_pkg::tap_idle;
      tap_pkg::tap_idle: tap_next = mode ? tap_pkg::tap_sel_dr : tap_pkg::tap_idle;
      tap_pkg::tap_sel_dr: tap_next = mode ? tap_pkg::tap_sel_ir : tap_pkg::tap_cap_dr;
      tap_pkg::tap_cap_dr: tap_next = mode ? tap_pkg::tap_ex1_dr : tap_pkg::tap_shift_dr;
      tap_pkg::tap_shift_dr: tap_next = mode ? tap_pkg::tap_ex1_dr : tap_pkg::tap_shift_dr;
      tap_pkg::tap_ex1_dr: tap_next = mode ? tap_pkg::tap_upd_dr : tap_pkg::tap_pause_dr;
      tap_pkg::tap_pause_dr: tap_next = mode ? tap_pkg::tap_ex2_dr : tap_pkg::tap_pause_dr;
      tap_pkg::tap_ex2_dr: tap_next = mode ? tap_pkg::tap_upd_dr : tap_pkg::tap_shift_dr;
      tap_pkg::tap_upd_dr: tap_next = mode ? tap_pkg::tap_sel_dr : tap_pkg::tap_idle;
      tap_pkg::tap_sel_ir: tap_next = mode ? tap_pkg::tap_reset : tap_pkg::tap_cap_ir;
      tap_pkg::tap_cap_ir: tap_next = mode ? tap_pkg::tap_ex1_ir : tap_pkg::tap_shift_ir;
      tap_pkg::tap_shift_ir: tap_next = mode ? tap_pkg::tap_ex1_ir : tap_pkg::tap_shift_ir;
      tap_pkg::tap_ex1_ir: tap_next = mode ? tap_pkg::tap_upd_ir : tap_pkg::tap_pause_ir;
      tap_pkg::tap_pause_ir: tap_next = mode ? tap_pkg::tap_ex2_ir : tap_pkg::tap_pause_ir;
      tap_pkg::tap_ex2_ir: tap_next = mode ? tap_pkg::tap_upd_ir : tap_pkg::tap_shift_ir;
      tap_pkg::tap_upd_ir: tap_next = mode ? tap_pkg::tap_sel_dr : tap_pkg::tap_idle;
      default: tap_next = tap_pkg::tap_reset;
    endcase
  endfunction

  // Boundary capture vector
  function automatic logic [`TAP_BSR_MSB:0] bsr_capture(input tap_pkg::pad_sample_type p,
                                                        input logic ext);
    logic [`TAP_BSR_MSB:0] v;
    v = '0;
    v[`TAP_RSVD_BIT] = 1'b0;
    for (int i = 0; i < `TAP_OUT_CELLS; i++)
    begin
      // Enable directly above data
      v[`TAP_OUT_BASE + 2 * i + 1] = p.drive_enable[i];
      if (!ext && p.drive_enable[i])
      begin
        v[`TAP_OUT_BASE + 2 * i] = p.drive_data[i];
      end
      else
      begin
        v[`TAP_OUT_BASE + 2 * i] = p.pad_in[i];
      end
    end
    for (int j = 0; j < `TAP_IN_CELLS; j++)
    begin
      v[`TAP_IN_BASE + j] = p.in_pin[j];
    end
    return v;
  endfunction

  // Pad levels into the test clock domain
  assign pad_now.pad_in = pad_in;
  assign pad_now.drive_data = s_reg.pad_data;
  assign pad_now.drive_enable = s_reg.pad_enable;
  assign pad_now.in_pin = in_pin;

  level_sync #(
    .WIDTH(`TAP_SAMPLE_WIDTH)
  ) pad_sync (
    .clock(tck),
    .clear(1'b0),
    .level_in(pad_now),
    .level_out(pad_seen)
  );

  assign dr_sel = dr_select(t_reg.ir_out);

  // Test clock domain, rising edge
  always_comb
  begin
    t_next = t_reg;
    t_next.state = tap_next(t_reg.state, tms);
    case (t_reg.state)
      tap_pkg::tap_reset:
      begin
        t_next.ir_out = `TAP_IR_IDCODE;
      end
      tap_pkg::tap_cap_ir:
      begin
        t_next.ir_shift = `TAP_IR_CAPTURE;
      end
      tap_pkg::tap_shift_ir:
      begin
        t_next.ir_shift = {tdi, t_reg.ir_shift[`TAP_IR_MSB:1]};
      end
      tap_pkg::tap_upd_ir:
      begin
        t_next.ir_out = t_reg.ir_shift;
      end
      tap_pkg::tap_cap_dr:
      begin
        case (dr_sel)
          tap_pkg::sel_bsr: t_next.bsr_shift = bsr_capture(pad_seen, t_reg.extest);
          tap_pkg::sel_id: t_next.id_shift = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
          default: t_next.bypass = 1'b0;
        endcase
      end
      tap_pkg::tap_shift_dr:
      begin
        case (dr_sel)
          tap_pkg::sel_bsr: t_next.bsr_shift = {tdi, t_reg.bsr_shift[`TAP_BSR_MSB:1]};
          tap_pkg::sel_id: t_next.id_shift = {tdi, t_reg.id_shift[`TAP_ID_MSB:1]};
          default: t_next.bypass = tdi;
        endcase
      end
      tap_pkg::tap_upd_dr:
      begin
        if (dr_sel == tap_pkg::sel_bsr)
        begin
          t_next.bsr_out = t_reg.bsr_shift;
        end
      end
      default:
      begin
      end
    endcase
    // Mode flags follow the active instruction
    t_next.extest = (t_next.ir_out == `TAP_IR_EXTEST);
    t_next.highz = (t_next.ir_out == `TAP_IR_HIGHZ);
  end

  // Halted tck holds every test clock flop; trst_n resets t_reg and tdo_reg without a clock edge, but not the pad_sync stages
  always_ff @(posedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      t_reg <= tap_pkg::tck_reset_value;
    end
    else
    begin
      t_reg <= t_next;
    end
  end

  // Test clock domain, falling edge
  always_comb
  begin
    tdo_next = tdo_reg;
    if (t_reg.state == tap_pkg::tap_shift_ir)
    begin
      tdo_next = t_reg.ir_shift[0];
    end
    else if (t_reg.state == tap_pkg::tap_shift_dr)
    begin
      case (dr_sel)
        tap_pkg::sel_bsr: tdo_next = t_reg.bsr_shift[0];
        tap_pkg::sel_id: tdo_next = t_reg.id_shift[0];
        default: tdo_next = t_reg.bypass;
      endcase
    end
  end

  always_ff @(negedge tck or negedge trst_n)
  begin
    if (!trst_n)
    begin
      tdo_reg <= 1'b0;
    end
    else
    begin
      tdo_reg <= tdo_next;
    end
  end

  assign tdo = tdo_reg;

  // Test drive into the system domain
  always_comb
  begin
    drive_tck.extest = t_reg.extest;
    drive_tck.highz = t_reg.highz;
    for (int i = 0; i < `TAP_OUT_CELLS; i++)
    begin
      drive_tck.data[i] = t_reg.bsr_out[`TAP_OUT_BASE + 2 * i];
      drive_tck.enable[i] = t_reg.bsr_out[`TAP_OUT_BASE + 2 * i + 1];
    end
  end

  level_sync #(
    .WIDTH(`TAP_DRIVE_WIDTH)
  ) drive_sync (
    .clock(clock),
    .clear(reset),
    .level_in(drive_tck),
    .level_out(drive_sys)
  );

  // System domain pad multiplexer
  always_comb
  begin
    s_next.pad_data = core_out_data;
    s_next.pad_enable = core_out_enable;
    if (drive_sys.highz)
    begin
      s_next.pad_enable = '0;
    end
    else if (drive_sys.extest)
    begin
      s_next.pad_data = drive_sys.data;
      s_next.pad_enable = drive_sys.enable;
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign pad_out_data = s_reg.pad_data;
  assign pad_out_enable = s_reg.pad_enable;

  // Checks on the test clock domain
  a_tms_reset_five:
  assert property (@(posedge tck) disable iff (!trst_n)
    tms [*5] |=> t_reg.state == tap_pkg::tap_reset)
  else $error("five high mode cycles did not reach reset");

  a_ir_capture_value:
  assert property (@(posedge tck) disable iff (!trst_n)
    t_reg.state == tap_pkg::tap_cap_ir |=> t_reg.ir_shift == `TAP_IR_CAPTURE)
  else $error("instruction capture pattern wrong");

  a_ir_shift_step:
  assert property (@(posedge tck) disable iff (!trst_n)
    t_reg.state == tap_pkg::tap_shift_ir
    |=> t_reg.ir_shift == {$past(tdi), $past(t_reg.ir_shift[`TAP_IR_MSB:1])})
  else $error("instruction shift step wrong");

  a_ir_out_hold:
  assert property (@(posedge tck) disable iff (!trst_n)
    (t_reg.state != tap_pkg::tap_upd_ir && t_reg.state != tap_pkg::tap_reset)
    |=> $stable(t_reg.ir_out))
  else $error("active instruction changed outside update");

  a_reset_loads_id:
  assert property (@(posedge tck) disable iff (!trst_n)
    t_reg.state == tap_pkg::tap_reset |=> t_reg.ir_out == `TAP_IR_IDCODE)
  else $error("reset did not load identify instruction");

  a_bsr_shift_step:
  assert property (@(posedge tck) disable iff (!trst_n)
    (t_reg.state == tap_pkg::tap_shift_dr && dr_sel == tap_pkg::sel_bsr)
    |=> t_reg.bsr_shift[`TAP_BSR_MSB] == $past(tdi)
        && t_reg.bsr_shift[`TAP_BSR_MSB-1:0] == $past(t_reg.bsr_shift[`TAP_BSR_MSB:1]))
  else $error("boundary shift step wrong");

  a_bsr_update_copy:
  assert property (@(posedge tck) disable iff (!trst_n)
    (t_reg.state == tap_pkg::tap_upd_dr && dr_sel == tap_pkg::sel_bsr)
    |=> t_reg.bsr_out == $past(t_reg.bsr_shift))
  else $error("boundary output stage not updated");

  a_bypass_one_bit:
  assert property (@(posedge tck) disable iff (!trst_n)
    (t_reg.state == tap_pkg::tap_shift_dr && dr_sel == tap_pkg::sel_bypass)
    ##1 t_reg.state == tap_pkg::tap_shift_dr
    |-> tdo == $past(tdi))
  else $error("bypass path is not one bit long");

  a_id_lsb_one:
  assert property (@(posedge tck) disable iff (!trst_n)
    (t_reg.state == tap_pkg::tap_cap_dr && dr_sel == tap_pkg::sel_id)
    |=> t_reg.id_shift[0] == 1'b1 && t_reg.id_shift[31:28] == ID_VERSION)
  else $error("identification capture wrong");

endmodule // boundary_scan_tap

// [scan_tester.sv]
// Test-port master model that drives the scan chain
`timescale 1ns/10ps

module scan_tester (
  // Test port
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  initial
  begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
  end

  // One test clock period, clock parked low afterwards
  task automatic step(input logic m, input logic d, input int stall, output logic q);
    tms = m;
    tdi = d;
    #(16 + stall);
    q = tdo;
    tck = 1'b1;
    #(16 + stall);
    tck = 1'b0;
  endtask

  // Mode-select walk, first bit first
  task automatic walk(input logic [15:0] pat, input int n);
    logic q;
    for (int k = 0; k < n; k++)
      step(pat[k], 1'b1, 0, q);
  endtask

  // Async test reset with clock stopped, then park in idle
  task automatic restart();
    logic q;
    trst_n = 1'b0;
    #40;
    trst_n = 1'b1;
    #20;
    step(1'b0, 1'b1, 0, q);
  endtask

  // Instruction or data scan from idle back to idle
  task automatic scan(input logic ir, input int n, input logic [296:0] din, input int stall,
    output logic [296:0] dout);
    logic q;
    dout = '0;
    step(1'b1, 1'b1, 0, q);
    if (ir)
      step(1'b1, 1'b1, 0, q);
    step(1'b0, 1'b1, 0, q);
    step(1'b0, 1'b1, 0, q);
    for (int k = 0; k < n; k++)
    begin
      step(k == n - 1, din[k], (k == n / 2) ? stall : 0, q);
      dout[k] = q;
    end
    step(1'b1, 1'b1, 0, q);
    step(1'b0, 1'b1, 0, q);
  endtask
endmodule // scan_tester

// [tb.sv]
// Self-checking bench of the boundary-scan test port
`timescale 1ns/10ps
`include "tap_map.svh"

module tb;
  // Identification fields, values arbitrary
  localparam logic [3:0] IDV = 4'h3;
  localparam logic [15:0] IDP = 16'h4c21;
  localparam logic [10:0] IDM = 11'h155;
  localparam logic [31:0] ID_EXP = {IDV, IDP, IDM, 1'b1};
  localparam int N = `TAP_OUT_CELLS;
  localparam logic [296:0] PAT = {33{9'h0b5}};
  localparam logic [N-1:0] FRC = {29{5'h09}};
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic tck, trst_n, tms, tdi, tdo;
  logic [N-1:0] core_d, core_e, ext_pad, pad_in, pad_d, pad_e;
  logic [5:0] in_pin;
  logic [296:0] got;
  int failures = 0;
  int tests_run = 0;

  always #2.5 clock = ~clock;
  // Resolved level of each bidirectional pad, forced pads overpowered from outside
  assign pad_in = (pad_e & ~FRC & pad_d) | (~(pad_e & ~FRC) & ext_pad);

  boundary_scan_tap #(.ID_VERSION(IDV), .ID_PART(IDP), .ID_MAKER(IDM)) dut (
    .clock(clock), .reset(reset), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
    .tdo(tdo), .core_out_data(core_d), .core_out_enable(core_e), .pad_in(pad_in),
    .pad_out_data(pad_d), .pad_out_enable(pad_e), .in_pin(in_pin));

  scan_tester tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo));

  task automatic report_and_stop();
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [296:0] seen, input logic [296:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Expected capture for a given pad drive
  function automatic logic [296:0] cap(input logic [N-1:0] d, input logic [N-1:0] e,
    input logic x);
    logic [296:0] r;
    r = '0;
    for (int i = 0; i < N; i++)
    begin
      r[1 + 2 * i] = (e[i] && !(x && FRC[i])) ? d[i] : ext_pad[i];
      r[2 + 2 * i] = e[i];
    end
    r[296:291] = in_pin;
    return r;
  endfunction

  // Bounded wait for the pad drive, then compare
  task automatic pads(input logic [N-1:0] d, input logic [N-1:0] e);
    for (int k = 0; k < 40 && {pad_e, pad_d} !== {e, d}; k++)
      @(negedge clock);
    check(297'({pad_e, pad_d}), 297'({e, d}));
  endtask

  task automatic ir_load(input logic [4:0] code);
    tester.scan(1'b1, 5, 297'(code), 0, got);
    check(got, 297'h01);
  endtask

  task automatic t_id();
    tester.scan(1'b0, 32, '0, 0, got);
    check(got, 297'(ID_EXP));
  endtask

  task automatic t_bypass();
    logic [4:0] codes [3] = '{5'h1f, 5'h07, 5'h03};
    for (int k = 0; k < 3; k++)
    begin
      ir_load(codes[k]);
      tester.scan(1'b0, 8, 297'h0b4, 500, got);
      check(got, 297'h068);
    end
    for (int k = 0; k < 40 && pad_e !== '0; k++)
      @(negedge clock);
    check(297'(pad_e), '0);
  endtask

  task automatic t_sample();
    ir_load(5'h01);
    tester.scan(1'b0, 297, PAT, 0, got);
    check(got, cap(core_d, core_e, 1'b0));
    pads(core_d, core_e);
  endtask

  task automatic t_extest();
    logic [N-1:0] d, e;
    for (int i = 0; i < N; i++)
    begin
      d[i] = PAT[1 + 2 * i];
      e[i] = PAT[2 + 2 * i];
    end
    ir_load(5'h00);
    pads(d, e);
    tester.scan(1'b0, 297, ~PAT, 0, got);
    check(got, cap(d, e, 1'b1));
    pads(~d, ~e);
    ir_load(5'h02);
    pads(core_d, core_e);
  endtask

  task automatic t_tms();
    ir_load(5'h1f);
    tester.walk(16'h00f9, 9);
    tester.scan(1'b0, 32, '0, 0, got);
    check(got, 297'(ID_EXP));
  endtask

  task automatic t_trst();
    ir_load(5'h1f);
    tester.restart();
    tester.scan(1'b0, 32, '0, 0, got);
    check(got, 297'(ID_EXP));
  endtask

  initial
  begin
    core_d = {29{5'h15}};
    core_e = {29{5'h0e}};
    ext_pad = {29{5'h13}};
    in_pin = 6'h2d;
    repeat (10) @(negedge clock);
    reset = 1'b0;
    tester.restart();
    t_id();
    t_bypass();
    t_sample();
    t_extest();
    t_tms();
    t_trst();
    report_and_stop();
  end

  initial
  begin
    #400000;
    failures++;
    report_and_stop();
  end
endmodule // tb
